// File: design/rsp_pkg.sv
// Constants for the ratioed sync pulse generator and its distribution.
// Assumes one core clock; every other domain is ratioed to it.
package rsp_pkg;

	// Pipeline shape: generation flop, distribution stages, header latch
	localparam int GEN_STAGES  = 1;
	localparam int DIST_STAGES = 5;
	localparam int HDR_STAGES  = 1;
	localparam int PIPE_DEPTH  = GEN_STAGES + DIST_STAGES + HDR_STAGES;

	// Enable lanes carried on the distribution pipeline
	localparam int LANE_DR_LAUNCH  = 0;
	localparam int LANE_DR_CAPTURE = 1;
	localparam int LANE_IO         = 2;
	localparam int LANE_IO2X       = 3;
	localparam int LANES           = 4;

	// Ratio table span: core cycles per four memory cycles
	localparam logic [4:0] RATIO_MIN = 5'h08;
	localparam logic [4:0] RATIO_MAX = 5'h15;
	localparam int         POS_W     = 5;

	// Alignment shift codes for the memory-domain pulses
	localparam logic [1:0] SHIFT_NONE  = 2'h0;
	localparam logic [1:0] SHIFT_PLUS  = 2'h1;
	localparam logic [1:0] SHIFT_MINUS = 2'h2;

	// Core-to-system pulse is decoded on this phase of the system period and is registered one cycle later
	localparam logic [7:0] SYS_ACTIVE_PHASE = 8'h02;

	// Default integer dividers of the peripheral clocks and system clock
	localparam int IO2X_DIV_DEF = 2;
	localparam int IO_DIV_DEF   = 4;
	localparam int SYS_DIV_DEF  = 8;

	// Stable indication waits this many cycles beyond the pipe fill
	localparam logic [7:0] SETTLE_CYCLES = 8'h20;

	// Generator states
	typedef enum logic [2:0] {
		RSP_IDLE   = 3'b001,
		RSP_FILL   = 3'b010,
		RSP_STABLE = 3'b100
	} rsp_state_t;

endpackage

// File: design/rsp_sync_pulse_gen.sv
// Sync pulse generator and global distribution for ratioed clock domains.
// Assumes the core clock is the only clock; memory, peripheral and system
// clocks are rational fractions of it with phase 0 at reset release.
`timescale 1ns/100ps

module rsp_sync_pulse_gen #(
	parameter int IO2X_DIV = rsp_pkg::IO2X_DIV_DEF,
	parameter int IO_DIV   = rsp_pkg::IO_DIV_DEF,
	parameter int SYS_DIV  = rsp_pkg::SYS_DIV_DEF
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [4:0] core_mem_ratio,
	input  wire logic [1:0] align_shift,
	input  wire logic       clocks_valid,
	output logic            hdr_mem_launch_enable,
	output logic            hdr_mem_capture_enable,
	output logic            hdr_io_xfer_enable,
	output logic            core_to_double_xfer_enable,
	output logic            double_to_core_xfer_enable,
	output logic            core_to_sys_sync,
	output logic            sys_to_core_sync,
	output logic            sync_stable
);

	// ****************************************************************
	// Timing overview
	// ****************************************************************

	// Every phase counter clears under reset and starts counting on the
	// first core edge after release, so that edge is phase 0 for every
	// derived clock at once.
	//
	// A memory pulse is decided in the cycle whose phase matches a table
	// slot, then loaded into the generation flop on the next edge.
	//
	// The generation flop, five distribution stages and the header latch
	// make seven core stages; a pulse decided in phase p is seen at the
	// header outputs seven edges later.
	//
	// The cluster flops the header outputs once more on its local clock,
	// which is why the transfer flops see each enable one cycle late.
	//
	// Launch and capture lanes share one position set: the safe window
	// for both directions is the same in this table, and one lane pair
	// costs less than two tables that could drift apart.
	//
	// The peripheral lanes come from plain integer dividers and do not
	// see the alignment shift; only the memory lanes move.
	//
	// The system pair skips the distribution pipeline entirely; the reset
	// unit sits next to this block and adds its own two flops.
	//
	// Limitation: ratio and shift are sampled every cycle but are meant
	// to be static. A change outside reset restarts the memory phase at
	// an arbitrary point and may drop or double one pulse; the stable
	// indication stays up unless the new ratio is out of range.
	//
	// An out-of-range ratio leaves the memory lanes silent rather than
	// guessing positions; a silent lane cannot corrupt a crossing, a
	// wrongly placed one can.
	//
	// Stable waits for the pipeline to fill plus a settle margin, so the
	// reset unit never releases the chip while a stage still holds an
	// enable decided before all clocks were valid.

	// ****************************************************************
	// Ratio table
	// ****************************************************************

	// Four positions per memory period, packed {p3,p2,p1,p0}
	function automatic logic [19:0] pos_table(input logic [4:0] n);
		logic [19:0] t;
		t = 20'h0;
		case (n)
			5'h08: t = {5'd7,  5'd5,  5'd3, 5'd1};
			5'h09: t = {5'd8,  5'd6,  5'd3, 5'd1};
			5'h0A: t = {5'd9,  5'd6,  5'd4, 5'd1};
			5'h0B: t = {5'd10, 5'd7,  5'd4, 5'd1};
			5'h0C: t = {5'd10, 5'd7,  5'd4, 5'd1};
			5'h0D: t = {5'd11, 5'd8,  5'd5, 5'd2};
			5'h0E: t = {5'd12, 5'd9,  5'd5, 5'd2};
			5'h0F: t = {5'd13, 5'd9,  5'd6, 5'd2};
			5'h10: t = {5'd14, 5'd10, 5'd6, 5'd2};
			5'h11: t = {5'd15, 5'd11, 5'd6, 5'd2};
			5'h12: t = {5'd16, 5'd11, 5'd7, 5'd2};
			5'h13: t = {5'd17, 5'd12, 5'd7, 5'd2};
			5'h14: t = {5'd17, 5'd12, 5'd7, 5'd2};
			5'h15: t = {5'd18, 5'd13, 5'd8, 5'd3};
			default: t = 20'h0;
		endcase
		return t;
	endfunction

	logic        ratio_ok;
	logic [19:0] positions;
	assign ratio_ok  = (core_mem_ratio >= rsp_pkg::RATIO_MIN) &&
	                   (core_mem_ratio <= rsp_pkg::RATIO_MAX);
	assign positions = pos_table(core_mem_ratio);

	// ****************************************************************
	// Phase counters
	// ****************************************************************

	logic [4:0] mem_phase_ff;
	logic [4:0] nxt_mem_phase;
	logic [7:0] io2x_phase_ff;
	logic [7:0] io_phase_ff;
	logic [7:0] sys_phase_ff;

	// Memory period wraps at the ratio so the pattern repeats
	assign nxt_mem_phase = (mem_phase_ff >= core_mem_ratio - 5'h01) ?
	                       5'h00 : mem_phase_ff + 5'h01;

	// Phase 0 is the nominal alignment of core and memory clocks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_phase_ff <= 5'h00;
		end else begin
			mem_phase_ff <= ratio_ok ? nxt_mem_phase : 5'h00;
		end
	end

	// Peripheral and system clocks are integer divisions of the core
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io2x_phase_ff <= 8'h00;
			io_phase_ff   <= 8'h00;
			sys_phase_ff  <= 8'h00;
		end else begin
			io2x_phase_ff <= (io2x_phase_ff == 8'(IO2X_DIV - 1)) ?
			                 8'h00 : io2x_phase_ff + 8'h01;
			io_phase_ff   <= (io_phase_ff == 8'(IO_DIV - 1)) ?
			                 8'h00 : io_phase_ff + 8'h01;
			sys_phase_ff  <= (sys_phase_ff == 8'(SYS_DIV - 1)) ?
			                 8'h00 : sys_phase_ff + 8'h01;
		end
	end

	// ****************************************************************
	// Pulse decode
	// ****************************************************************

	// Shift moves the memory hit point; positive shift wraps backwards
	logic [4:0] shifted_phase;
	always_comb begin
		case (align_shift)
			rsp_pkg::SHIFT_PLUS:
				shifted_phase = (mem_phase_ff == 5'h00) ?
				                core_mem_ratio - 5'h01 :
				                mem_phase_ff - 5'h01;
			rsp_pkg::SHIFT_MINUS:
				shifted_phase = nxt_mem_phase;
			default:
				shifted_phase = mem_phase_ff;
		endcase
	end

	// One hit per memory cycle: four table slots per four-cycle period
	logic [3:0] slot_hit;
	genvar s;
	generate
		for (s = 0; s < 4; s++) begin : g_slot
			assign slot_hit[s] = ratio_ok &&
				(shifted_phase == positions[s*5 +: 5]);
		end
	endgenerate

	// Launch and capture share the safe window; io lanes ignore the shift
	logic [rsp_pkg::LANES-1:0] gen_lanes;
	always_comb begin
		gen_lanes = '0;
		gen_lanes[rsp_pkg::LANE_DR_LAUNCH]  = |slot_hit;
		gen_lanes[rsp_pkg::LANE_DR_CAPTURE] = |slot_hit;
		gen_lanes[rsp_pkg::LANE_IO]         = (io_phase_ff == 8'h00);
		gen_lanes[rsp_pkg::LANE_IO2X]       = (io2x_phase_ff == 8'h00);
	end

	// ****************************************************************
	// Distribution pipeline
	// ****************************************************************

	// Stage 0 is the generation flop, the last is the header latch
	logic [rsp_pkg::LANES-1:0] pipe_ff [rsp_pkg::PIPE_DEPTH];

	genvar k;
	generate
		for (k = 0; k < rsp_pkg::PIPE_DEPTH; k++) begin : g_pipe
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					pipe_ff[k] <= '0;
				end else if (k == 0) begin
					pipe_ff[k] <= gen_lanes;
				end else begin
					pipe_ff[k] <= pipe_ff[k-1];
				end
			end
		end
	endgenerate

	// Header outputs; the cluster flop adds the one-cycle delay
	logic [rsp_pkg::LANES-1:0] hdr_out;
	assign hdr_out = pipe_ff[rsp_pkg::PIPE_DEPTH-1];

	assign hdr_mem_launch_enable  = hdr_out[rsp_pkg::LANE_DR_LAUNCH];
	assign hdr_mem_capture_enable = hdr_out[rsp_pkg::LANE_DR_CAPTURE];
	assign hdr_io_xfer_enable     = hdr_out[rsp_pkg::LANE_IO];

	// Single source feeds both double-rate directions so they never skew
	assign core_to_double_xfer_enable = hdr_out[rsp_pkg::LANE_IO2X];
	assign double_to_core_xfer_enable = hdr_out[rsp_pkg::LANE_IO2X];

	// ****************************************************************
	// Reset unit pulse pair
	// ****************************************************************

	// Sent straight to the reset unit, which double-flops them itself
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_to_sys_sync <= 1'b0;
			sys_to_core_sync <= 1'b0;
		end else begin
			core_to_sys_sync <=
				(sys_phase_ff == rsp_pkg::SYS_ACTIVE_PHASE);
			sys_to_core_sync <=
				(sys_phase_ff == rsp_pkg::SYS_ACTIVE_PHASE);
		end
	end

	// ****************************************************************
	// Stable indication
	// ****************************************************************

	// Wait for pipe fill plus settle time; ratio change needs a reset
	rsp_pkg::rsp_state_t state_ff;
	logic [7:0]          settle_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= rsp_pkg::RSP_IDLE;
			settle_ff <= 8'h00;
		end else begin
			case (state_ff)
				rsp_pkg::RSP_IDLE: begin
					settle_ff <= 8'h00;
					if (clocks_valid && ratio_ok) begin
						state_ff <= rsp_pkg::RSP_FILL;
					end
				end
				rsp_pkg::RSP_FILL: begin
					if (!clocks_valid || !ratio_ok) begin
						state_ff <= rsp_pkg::RSP_IDLE;
					end else if (settle_ff == rsp_pkg::SETTLE_CYCLES
					             + 8'(rsp_pkg::PIPE_DEPTH)) begin
						state_ff <= rsp_pkg::RSP_STABLE;
					end else begin
						settle_ff <= settle_ff + 8'h01;
					end
				end
				rsp_pkg::RSP_STABLE: begin
					if (!clocks_valid || !ratio_ok) begin
						state_ff <= rsp_pkg::RSP_IDLE;
					end
				end
				default: state_ff <= rsp_pkg::RSP_IDLE;
			endcase
		end
	end

	// Registered so the reset unit never sees a decode glitch
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync_stable <= 1'b0;
		end else begin
			sync_stable <= (state_ff == rsp_pkg::RSP_STABLE) &&
			               clocks_valid;
		end
	end

endmodule // rsp_sync_pulse_gen

// File: testbench/rsp_chk.sv
// Port checker for the sync pulse generator, bound to its top module.
// Assumes ratio and shift stay static between resets.
`timescale 1ns/100ps
module rsp_chk #(
	parameter int SYS_DIV = 8
) (
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [4:0] core_mem_ratio,
	input wire logic [1:0] align_shift,
	input wire logic       clocks_valid,
	input wire logic       hdr_mem_launch_enable,
	input wire logic       hdr_mem_capture_enable,
	input wire logic       hdr_io_xfer_enable,
	input wire logic       core_to_double_xfer_enable,
	input wire logic       double_to_core_xfer_enable,
	input wire logic       core_to_sys_sync,
	input wire logic       sys_to_core_sync,
	input wire logic       sync_stable
);
	localparam int MIN_FILL = 32;
	logic [7:0] gap_ff;
	logic [7:0] run_ff;
	logic       bad;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Ratio outside the table span
	assign bad = core_mem_ratio < 5'h08 || core_mem_ratio > 5'h15;
	// Cycles since the last system pulse; FF means none seen yet
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			gap_ff <= 8'hFF;
		else if (core_to_sys_sync)
			gap_ff <= 8'h00;
		else if (gap_ff != 8'hFF)
			gap_ff <= gap_ff + 8'h01;
	end
	// Run of valid-clock cycles; saturates so it never wraps to zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			run_ff <= 8'h00;
		else
			run_ff <= !clocks_valid ? 8'h00 : run_ff + {7'h00, run_ff != 8'hFF};
	end
	sequence s_quiet; ##1 !hdr_mem_launch_enable; endsequence
	property p_pair2x;
		core_to_double_xfer_enable == double_to_core_xfer_enable;
	endproperty
	a_pair2x: assert property (p_pair2x) else $error("io2x pair split");
	property p_sys_pair; core_to_sys_sync == sys_to_core_sync; endproperty
	a_sys_pair: assert property (p_sys_pair) else $error("sys pair split");
	property p_lc; hdr_mem_launch_enable == hdr_mem_capture_enable; endproperty
	a_lc: assert property (p_lc) else $error("launch/capture differ");
	property p_gap; hdr_mem_launch_enable |-> s_quiet; endproperty
	a_gap: assert property (p_gap) else $error("memory pulse too long");
	property p_io_tie; hdr_io_xfer_enable |-> core_to_double_xfer_enable; endproperty
	a_io_tie: assert property (p_io_tie) else $error("io off io2x");
	property p_sys_pos;
		gap_ff != 8'hFF |-> core_to_sys_sync == (gap_ff == 8'(SYS_DIV - 1));
	endproperty
	a_sys_pos: assert property (p_sys_pos) else $error("sys period");
	property p_drop; !clocks_valid || bad |-> ##2 !sync_stable; endproperty
	a_drop: assert property (p_drop) else $error("stable kept");
	property p_fill; $rose(sync_stable) |-> run_ff >= MIN_FILL; endproperty
	a_fill: assert property (p_fill) else $error("stable too early");
	property p_bad; bad |-> !hdr_mem_launch_enable; endproperty
	a_bad: assert property (p_bad) else $error("pulse on bad ratio");
endmodule // rsp_chk

bind rsp_sync_pulse_gen rsp_chk #(.SYS_DIV(SYS_DIV)) u_rsp_chk (.*);

// File: testbench/rsp_cluster_model.sv
// Cluster side: local enable flops and the reset unit's two stages.
// Assumes the cluster clock is the core clock with no skew.
`timescale 1ns/100ps
module rsp_cluster_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [3:0] hdr_en,
	input  wire logic       sys_sync,
	output logic      [3:0] loc_en_ff,
	output logic            loc_c2d,
	output logic            loc_d2c,
	output logic      [1:0] sys_ff
);
	// One local flop per enable before fan-out to the transfer flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			loc_en_ff <= 4'h0;
		else
			loc_en_ff <= hdr_en;
	end
	// Both io2x directions share one flop so they never disagree
	assign loc_c2d = loc_en_ff[3];
	assign loc_d2c = loc_en_ff[3];
	// Two stages soak up fan-out inside the reset unit
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			sys_ff <= 2'h0;
		else
			sys_ff <= {sys_ff[0], sys_sync};
	end
endmodule // rsp_cluster_model

// File: testbench/rsp_sync_pulse_gen_tb.sv
// Self-checking bench for the sync pulse generator with a cluster model.
// Assumes default dividers: io2x 2, io 4, system 8.
`timescale 1ns/100ps
module rsp_sync_pulse_gen_tb;
	logic clock, resetn, clocks_valid, hdr_mem_launch_enable, sync_stable;
	logic hdr_mem_capture_enable, hdr_io_xfer_enable, core_to_sys_sync;
	logic core_to_double_xfer_enable, double_to_core_xfer_enable;
	logic sys_to_core_sync, loc_c2d, loc_d2c;
	logic [4:0] core_mem_ratio;
	logic [1:0] align_shift, sys_loc;
	logic [3:0] loc_en;
	int         error_cnt, check_count;
	int pos[8:21][4] = '{'{1,3,5,7}, '{1,3,6,8}, '{1,4,6,9}, '{1,4,7,10},
		'{1,4,7,10}, '{2,5,8,11}, '{2,5,9,12}, '{2,6,9,13}, '{2,6,10,14},
		'{2,6,11,15}, '{2,7,11,16}, '{2,7,12,17}, '{2,7,12,17}, '{3,8,13,18}};
	rsp_sync_pulse_gen uut (.*);
	rsp_cluster_model u_model (.clock(clock), .resetn(resetn),
		.hdr_en({core_to_double_xfer_enable, hdr_io_xfer_enable,
		hdr_mem_capture_enable, hdr_mem_launch_enable}),
		.sys_sync(core_to_sys_sync), .loc_en_ff(loc_en), .loc_c2d(loc_c2d),
		.loc_d2c(loc_d2c), .sys_ff(sys_loc));
	// 50 ns core clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Settings change only under reset; launch, io, io2x, system and stable outputs must sit low there
	task automatic do_reset(input logic [4:0] r, input logic [1:0] s);
		@(posedge clock);
		resetn <= 1'b0;
		core_mem_ratio <= r;
		align_shift <= s;
		clocks_valid <= 1'b1;
		repeat (2) @(posedge clock);
		check({hdr_mem_launch_enable, hdr_io_xfer_enable, sync_stable,
			core_to_double_xfer_enable, core_to_sys_sync}, 8'h00);
		resetn <= 1'b1;
	endtask
	// Every lane is judged against its phase counted from the first io pulse
	task automatic t_pattern(input logic [4:0] r, input logic [1:0] s);
		int n, off, d;
		logic m;
		logic [3:0] prev;
		n = r;
		off = (s == 2'h1) ? 1 : (s == 2'h2) ? n - 1 : 0;
		d = -1;
		prev = 4'h0;
		do_reset(r, s);
		for (int k = 0; k < 40 + 3 * n; k++) begin
			@(negedge clock);
			if (d < 0 && hdr_io_xfer_enable) begin
				check(k, 7);
				d = 0;
			end
			if (d >= 0) begin
				m = 1'b0;
				for (int i = 0; i < 4; i++)
					m |= (pos[n][i] + off) % n == d % n;
				check(hdr_mem_launch_enable, m);
				check(hdr_mem_capture_enable, m);
				check(hdr_io_xfer_enable, d % 4 == 0);
				check(core_to_double_xfer_enable, d % 2 == 0);
				check(core_to_sys_sync, (d + 4) % 8 == 0);
				check(sys_to_core_sync, (d + 4) % 8 == 0);
				check(sys_loc[1], (d + 2) % 8 == 0);
				check(double_to_core_xfer_enable,
					core_to_double_xfer_enable);
				check(loc_d2c, loc_c2d);
				d++;
			end
			check(loc_en, prev);
			prev = {core_to_double_xfer_enable, hdr_io_xfer_enable,
				hdr_mem_capture_enable, hdr_mem_launch_enable};
		end
		check(d > 0, 1'b1);
		$display("pattern ratio %0d shift %0d done", r, s);
	endtask
	// Stable waits for fill and settle, then falls when clocks go bad
	task automatic t_stable;
		int k;
		k = 0;
		do_reset(5'h0B, 2'h0);
		while (!sync_stable && k < 200) begin
			@(negedge clock);
			k++;
		end
		check(k >= 39 && k <= 50, 1'b1);
		@(posedge clock);
		clocks_valid <= 1'b0;
		repeat (3) @(negedge clock);
		check(sync_stable, 1'b0);
		$display("stable done");
	endtask
	// Ratio outside the table: no memory pulses and never stable
	task automatic t_bad(input logic [4:0] r);
		int cnt;
		cnt = 0;
		do_reset(r, 2'h0);
		repeat (80) begin
			@(negedge clock);
			cnt += hdr_mem_launch_enable | sync_stable;
		end
		check(cnt, 0);
		$display("bad ratio %0d done", r);
	endtask
	// Main sequence
	initial begin
		resetn = 1'b0;
		core_mem_ratio = 5'h08;
		align_shift = 2'h0;
		clocks_valid = 1'b0;
		error_cnt = 0;
		check_count = 0;
		for (int r = 8; r <= 21; r++)
			t_pattern(5'(r), 2'h0);
		for (int s = 1; s < 4; s++)
			t_pattern(5'h0B, 2'(s));
		t_stable;
		t_bad(5'h07);
		t_bad(5'h16);
		finish_test;
	end
	// Watchdog well beyond the roughly 1700 cycles of the run
	initial begin
		#500000;
		error_cnt++;
		finish_test;
	end
endmodule // rsp_sync_pulse_gen_tb
